/* tmr_consts.vh */
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH
// ****************************************************
// register byte addresses
// ****************************************************
`define TMR_ADR_CTRL      8'h00
`define TMR_ADR_PRESCALE  8'h04
`define TMR_ADR_T1_COUNT  8'h08
`define TMR_ADR_T1_RELOAD 8'h0C
`define TMR_ADR_T2_COUNT  8'h10
`define TMR_ADR_T2_RLD_LO 8'h14
`define TMR_ADR_T2_RLD_HI 8'h18
`define TMR_ADR_LC_COUNT  8'h1C
`define TMR_ADR_T3_COUNT  8'h20
`define TMR_ADR_IRQ_STAT  8'h24
`define TMR_ADR_IRQ_CLR   8'h28
`define TMR_ADR_IRQ_EN    8'h2C
`define TMR_ADR_SKIP      8'h30
// ****************************************************
// control register fields
// ****************************************************
`define TMR_CTRL_PS_RUN   0
`define TMR_CTRL_T1_RUN   1
`define TMR_CTRL_T2_RUN   2
`define TMR_CTRL_LC_RUN   3
`define TMR_CTRL_T3_RUN   4
`define TMR_CTRL_PWM_EN   5
`define TMR_CTRL_PWM_EXT  6
`define TMR_CTRL_PIN_OUT  7
`define TMR_CTRL_T1_SRC   8
`define TMR_CTRL_T1_SYNC  9
`define TMR_CTRL_PORT_C   10
`define TMR_CTRL_T3_SRC   11
`define TMR_CTRL_W        12
`define TMR_CTRL_RST      12'h000
// ****************************************************
// flag bits: timer1, timer2, lc, timer3
// ****************************************************
`define TMR_FLG_T1        0
`define TMR_FLG_T2        1
`define TMR_FLG_LC        2
`define TMR_FLG_T3        3
`define TMR_FLG_W         4
`define TMR_FLG_RST       4'h0
`define TMR_BYTE_RST      8'h00
`define TMR_T3_RST        16'hFFFF
`define TMR_LC_RLD        4'hF
`endif

/* tmr_cpu.sv */
`timescale 1ns/100ps
// ****************
// cpu core side: transfer cycles
// ****************
module tmr_cpu (
    input  wire        clk_i,
    input  wire        ack_i,
    input  wire [31:0] dat_i,
    output reg         cyc_o,
    output reg         stb_o,
    output reg         we_o,
    output reg  [7:0]  adr_o,
    output wire [3:0]  sel_o,
    output reg  [31:0] dat_o
);
    assign sel_o = 4'hF;
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 8'h00;
        dat_o = 32'h0000_0000;
    end
    // no fixed latency assumed; only the bench timeout ends a wait
    task xfer(input reg w, input reg [7:0] a, input reg [31:0] d, output reg [31:0] q);
        begin
            @(posedge clk_i);
            cyc_o <= 1'b1;
            stb_o <= 1'b1;
            we_o  <= w;
            adr_o <= a;
            dat_o <= d;
            @(posedge clk_i);
            while (ack_i !== 1'b1) @(posedge clk_i);
            q = dat_i;
            cyc_o <= 1'b0;
            stb_o <= 1'b0;
            dat_o <= ~d;
            @(posedge clk_i);
        end
    endtask
endmodule // tmr_cpu

/* tmr_dcnt.v */
`timescale 1ns/100ps
// reloadable down counter shared by timer 1, timer 2 and the lc timer
module tmr_dcnt #(
    parameter W = 8
) (
    input  wire         clk_i,
    input  wire         srst_i,
    input  wire         ce_i,
    input  wire         run_i,
    input  wire         tick_i,
    input  wire         load_i,
    input  wire [W-1:0] load_val_i,
    input  wire [W-1:0] reload_val_i,
    output reg  [W-1:0] count_o,
    output wire         uf_o
);
    assign uf_o = run_i & tick_i & (count_o == {W{1'b0}});

    always @(posedge clk_i) begin
        if (srst_i) begin
            count_o <= {W{1'b1}};
        end else if (ce_i) begin
            if (load_i) begin
                count_o <= load_val_i;
            end else if (uf_o) begin
                count_o <= reload_val_i;
            end else if (run_i & tick_i) begin
                count_o <= count_o - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // tmr_dcnt

/* tmr_unit.v */
`timescale 1ns/100ps
`include "tmr_consts.vh"
// What this block does
// - prescaler and timer 1 count from first source rising edge after start
// - first underflow may come up to one source period early
// - timer 1 on the count pin advances on its falling edges
// - timer 2 and lc count from rising edge after first falling edge
// - a high port c latch drives the count pin high whenever the pin is an output
// - optional start of timer 1 synchronised to the interrupt pin
// - enable bit routes flag to interrupt, else to skip test
module tmr_unit (
    input  wire        CLK_I,
    input  wire        SRST_I,
    input  wire        CE_I,
    input  wire        CYC_I,
    input  wire        STB_I,
    input  wire        WE_I,
    input  wire [7:0]  ADR_I,
    input  wire [3:0]  SEL_I,
    input  wire [31:0] DAT_I,
    output reg  [31:0] DAT_O,
    output reg         ACK_O,
    input  wire        COUNT_IO_PIN_I,
    output wire        COUNT_IO_PIN_O,
    output wire        COUNT_IO_PIN_OE_O,
    input  wire        INT_PIN_I,
    output wire        IRQ_O
);
    // ****************************************************
    // registers
    // ****************************************************
    reg  [`TMR_CTRL_W-1:0] ctrl_reg;
    reg  [7:0]             ps_data_reg;
    reg  [7:0]             ps_cnt_reg;
    reg                    ps_lvl_reg;
    reg  [7:0]             t1_rld_reg;
    reg  [7:0]             t2_lo_reg;
    reg  [7:0]             t2_hi_reg;
    reg  [15:0]            t3_cnt_reg;
    reg  [`TMR_FLG_W-1:0]  flag_reg;
    reg  [`TMR_FLG_W-1:0]  flag_next;
    reg  [`TMR_FLG_W-1:0]  irq_en_reg;
    reg  [2:0]             count_io_pin_sync_reg;
    reg  [2:0]             int_sync_reg;
    reg                    t1_armed_reg;
    reg                    t2_armed_reg;
    reg                    lc_armed_reg;
    reg                    pwm_reg;
    reg                    ext_hold_reg;
    reg  [31:0]            rd_next;
    wire [7:0]             t1_cnt;
    wire [7:0]             t2_cnt;
    wire [3:0]             lc_cnt;
    wire                   t1_uf;
    wire                   t2_uf;
    wire                   lc_uf;

    wire req    = CYC_I & STB_I;
    wire acc    = req & ACK_O;
    wire wr     = acc & WE_I & SEL_I[0];
    wire wr_hi  = acc & WE_I & SEL_I[1];
    wire rd     = acc & ~WE_I;

    // ****************************************************
    // pin synchronisers
    // ****************************************************
    always @(posedge CLK_I) begin
        if (SRST_I) begin
            count_io_pin_sync_reg <= 3'b111;
            int_sync_reg  <= 3'b000;
        end else if (CE_I) begin
            count_io_pin_sync_reg <= {count_io_pin_sync_reg[1:0], COUNT_IO_PIN_I};
            int_sync_reg  <= {int_sync_reg[1:0], INT_PIN_I};
        end
    end

    // edge detectors look only at the second and third stages
    wire count_io_pin_fall = count_io_pin_sync_reg[2] & ~count_io_pin_sync_reg[1];
    wire int_edge  = int_sync_reg[2] ^ int_sync_reg[1];

    // ****************************************************
    // prescaler: square wave source, one level per expiry
    // ****************************************************
    wire ps_run  = ctrl_reg[`TMR_CTRL_PS_RUN];
    wire ps_exp  = ps_run & (ps_cnt_reg == 8'h00);
    wire ps_rise = ps_exp & ~ps_lvl_reg;
    wire ps_fall = ps_exp & ps_lvl_reg;

    always @(posedge CLK_I) begin
        if (SRST_I) begin
            ps_cnt_reg <= `TMR_BYTE_RST;
            ps_lvl_reg <= 1'b0;
        end else if (CE_I) begin
            if (wr && ADR_I == `TMR_ADR_PRESCALE) begin
                ps_cnt_reg <= DAT_I[7:0];
                ps_lvl_reg <= 1'b0;
            end else if (!ps_run) begin
                ps_lvl_reg <= 1'b0;   // restart low so the first edge is a rising one
            end else if (ps_exp) begin
                ps_cnt_reg <= ps_data_reg;
                ps_lvl_reg <= ~ps_lvl_reg;
            end else begin
                ps_cnt_reg <= ps_cnt_reg - 8'h01;
            end
        end
    end

    // ****************************************************
    // count sources and start qualification
    // ****************************************************
    wire t1_run  = ctrl_reg[`TMR_CTRL_T1_RUN];
    wire t2_run  = ctrl_reg[`TMR_CTRL_T2_RUN];
    wire lc_run  = ctrl_reg[`TMR_CTRL_LC_RUN];
    wire pwm_en  = ctrl_reg[`TMR_CTRL_PWM_EN];
    // source select taken live; software keeps it steady while running
    wire t1_src  = ctrl_reg[`TMR_CTRL_T1_SRC] ? count_io_pin_fall : ps_rise;
    wire t1_tick = t1_src & t1_armed_reg;
    wire t2_tick = ps_rise & t2_armed_reg & ~ext_hold_reg;
    wire lc_tick = ps_rise & lc_armed_reg;

    always @(posedge CLK_I) begin
        if (SRST_I) begin
            t1_armed_reg <= 1'b0;
            t2_armed_reg <= 1'b0;
            lc_armed_reg <= 1'b0;
        end else if (CE_I) begin
            if (!t1_run)
                t1_armed_reg <= 1'b0;
            else if (!ctrl_reg[`TMR_CTRL_T1_SYNC] || int_edge)
                t1_armed_reg <= 1'b1;
            if (!t2_run)
                t2_armed_reg <= 1'b0;
            else if (ps_fall)
                t2_armed_reg <= 1'b1;
            if (!lc_run)
                lc_armed_reg <= 1'b0;
            else if (ps_fall)
                lc_armed_reg <= 1'b1;
        end
    end

    // ****************************************************
    // timers 1, 2 and lc
    // ****************************************************
    // a running start never preloads, so the first period may be short
    tmr_dcnt #(.W(8)) u_t1 (
        .clk_i        (CLK_I),
        .srst_i       (SRST_I),
        .ce_i         (CE_I),
        .run_i        (t1_run),
        .tick_i       (t1_tick),
        .load_i       (wr && ADR_I == `TMR_ADR_T1_COUNT),
        .load_val_i   (DAT_I[7:0]),
        .reload_val_i (t1_rld_reg),
        .count_o      (t1_cnt),
        .uf_o         (t1_uf)
    );

    // pwm low phase ends: load high reload, else low reload
    wire [7:0] t2_rld = (pwm_en && !pwm_reg) ? t2_hi_reg : t2_lo_reg;

    tmr_dcnt #(.W(8)) u_t2 (
        .clk_i        (CLK_I),
        .srst_i       (SRST_I),
        .ce_i         (CE_I),
        .run_i        (t2_run),
        .tick_i       (t2_tick),
        .load_i       (wr && ADR_I == `TMR_ADR_T2_COUNT),
        .load_val_i   (DAT_I[7:0]),
        .reload_val_i (t2_rld),
        .count_o      (t2_cnt),
        .uf_o         (t2_uf)
    );

    tmr_dcnt #(.W(4)) u_lc (
        .clk_i        (CLK_I),
        .srst_i       (SRST_I),
        .ce_i         (CE_I),
        .run_i        (lc_run),
        .tick_i       (lc_tick),
        .load_i       (wr && ADR_I == `TMR_ADR_LC_COUNT),
        .load_val_i   (DAT_I[3:0]),
        .reload_val_i (`TMR_LC_RLD),
        .count_o      (lc_cnt),
        .uf_o         (lc_uf)
    );

    // pwm toggles at each timer 2 reload; extension adds one source tick high
    always @(posedge CLK_I) begin
        if (SRST_I) begin
            pwm_reg      <= 1'b0;
            ext_hold_reg <= 1'b0;
        end else if (CE_I) begin
            if (!pwm_en) begin
                pwm_reg      <= 1'b0;
                ext_hold_reg <= 1'b0;
            end else if (t2_uf) begin
                pwm_reg      <= ~pwm_reg;
                ext_hold_reg <= ~pwm_reg & ctrl_reg[`TMR_CTRL_PWM_EXT];
            end else if (ps_rise && t2_armed_reg) begin
                ext_hold_reg <= 1'b0;
            end
        end
    end

    // ****************************************************
    // timer 3: 16-bit, prescaler or system clock source
    // ****************************************************
    wire t3_tick = ctrl_reg[`TMR_CTRL_T3_RUN] &
                   (ctrl_reg[`TMR_CTRL_T3_SRC] | ps_rise);
    wire t3_uf   = t3_tick & (t3_cnt_reg == 16'h0000);

    always @(posedge CLK_I) begin
        if (SRST_I)
            t3_cnt_reg <= `TMR_T3_RST;
        else if (CE_I && t3_tick)
            t3_cnt_reg <= t3_cnt_reg - 16'h0001;
    end

    // ****************************************************
    // count pin: high latch overrides the timer output
    // ****************************************************
    assign COUNT_IO_PIN_OE_O = ctrl_reg[`TMR_CTRL_PIN_OUT];
    assign COUNT_IO_PIN_O    = ctrl_reg[`TMR_CTRL_PORT_C] | pwm_reg;

    // ****************************************************
    // request flags, skip test and interrupt
    // ****************************************************
    wire [`TMR_FLG_W-1:0] flag_set  = {t3_uf, lc_uf, t2_uf, t1_uf};
    wire [`TMR_FLG_W-1:0] skip_vis  = flag_reg & ~irq_en_reg;
    wire skip_rd = rd && ADR_I == `TMR_ADR_SKIP;
    wire clr_wr  = wr && ADR_I == `TMR_ADR_IRQ_CLR;

    always @* begin
        flag_next = flag_reg;
        if (clr_wr)
            flag_next = flag_next & ~DAT_I[`TMR_FLG_W-1:0];
        if (skip_rd)
            flag_next = flag_next & ~skip_vis;
        flag_next = flag_next | flag_set;   // a new underflow beats any clear
    end

    assign IRQ_O = |(flag_reg & irq_en_reg);

    // ****************************************************
    // wishbone slave: ack one cycle after the request
    // ****************************************************
    always @* begin
        rd_next = 32'h0000_0000;
        case (ADR_I)
            `TMR_ADR_CTRL:      rd_next[`TMR_CTRL_W-1:0] = ctrl_reg;
            `TMR_ADR_PRESCALE:  rd_next[7:0]  = ps_cnt_reg;
            `TMR_ADR_T1_COUNT:  rd_next[7:0]  = t1_cnt;
            `TMR_ADR_T1_RELOAD: rd_next[7:0]  = t1_rld_reg;
            `TMR_ADR_T2_COUNT:  rd_next[7:0]  = t2_cnt;
            `TMR_ADR_T2_RLD_LO: rd_next[7:0]  = t2_lo_reg;
            `TMR_ADR_T2_RLD_HI: rd_next[7:0]  = t2_hi_reg;
            `TMR_ADR_LC_COUNT:  rd_next[3:0]  = lc_cnt;
            `TMR_ADR_T3_COUNT:  rd_next[15:0] = t3_cnt_reg;
            `TMR_ADR_IRQ_STAT:  rd_next[`TMR_FLG_W-1:0] = flag_reg;
            `TMR_ADR_IRQ_EN:    rd_next[`TMR_FLG_W-1:0] = irq_en_reg;
            `TMR_ADR_SKIP:      rd_next[`TMR_FLG_W-1:0] = skip_vis;
            default:            rd_next = 32'h0000_0000;
        endcase
    end

    always @(posedge CLK_I) begin
        if (SRST_I) begin
            ACK_O       <= 1'b0;
            DAT_O       <= 32'h0000_0000;
            ctrl_reg    <= `TMR_CTRL_RST;
            ps_data_reg <= `TMR_BYTE_RST;
            t1_rld_reg  <= `TMR_BYTE_RST;
            t2_lo_reg   <= `TMR_BYTE_RST;
            t2_hi_reg   <= `TMR_BYTE_RST;
            flag_reg    <= `TMR_FLG_RST;
            irq_en_reg  <= `TMR_FLG_RST;
        end else if (CE_I) begin
            ACK_O    <= req & ~ACK_O;
            DAT_O    <= rd_next;
            flag_reg <= flag_next;
            if (wr) begin
                case (ADR_I)
                    `TMR_ADR_CTRL:      ctrl_reg[7:0] <= DAT_I[7:0];
                    `TMR_ADR_PRESCALE:  ps_data_reg   <= DAT_I[7:0];
                    `TMR_ADR_T1_RELOAD: t1_rld_reg    <= DAT_I[7:0];
                    `TMR_ADR_T2_RLD_LO: t2_lo_reg     <= DAT_I[7:0];
                    `TMR_ADR_T2_RLD_HI: t2_hi_reg     <= DAT_I[7:0];
                    `TMR_ADR_IRQ_EN:    irq_en_reg    <= DAT_I[`TMR_FLG_W-1:0];
                    default:            ;
                endcase
            end
            if (wr_hi && ADR_I == `TMR_ADR_CTRL)
                ctrl_reg[`TMR_CTRL_W-1:8] <= DAT_I[`TMR_CTRL_W-1:8];
        end
    end
endmodule // tmr_unit

/* tmr_unit_bench.sv */
`timescale 1ns/100ps
`include "tmr_consts.vh"
module tmr_unit_bench;
    reg         clk, srst, ce, pin_drv, int_pin;
    wire        cyc, stb, we, ack, count_io_pin_o, count_io_pin_oe, irq;
    wire [7:0]  adr;
    wire [3:0]  sel;
    wire [31:0] dwr, drd;
    wire        count_io_pin = count_io_pin_oe ? count_io_pin_o : pin_drv;
    integer     n_fail, num_checks, cycles;
    reg  [31:0] q;
    integer     width;
    localparam [1:0] see_irq = 2'h0;
    localparam [1:0] see_pin = 2'h1;
    localparam [1:0] see_oe  = 2'h2;
    tmr_cpu u_cpu (.clk_i(clk), .ack_i(ack), .dat_i(drd), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dwr));
    tmr_unit u_dut (.CLK_I(clk), .SRST_I(srst), .CE_I(ce), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dwr), .DAT_O(drd), .ACK_O(ack),
        .COUNT_IO_PIN_I(count_io_pin), .COUNT_IO_PIN_O(count_io_pin_o), .COUNT_IO_PIN_OE_O(count_io_pin_oe), .INT_PIN_I(int_pin),
        .IRQ_O(irq));
    task finish_test;
        begin
            if (n_fail == 0 && num_checks > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask
    task cmp(input reg [31:0] got, input reg [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("wrong value at %0t: got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task bit_is(input reg got, input reg exp);
        begin
            cmp({31'h0000_0000, got}, {31'h0000_0000, exp});
        end
    endtask
    // outputs looked at mid-cycle, where they have settled
    task out_is(input reg [1:0] which, input reg exp);
        begin
            @(negedge clk);
            case (which)
                see_irq: bit_is(irq, exp);
                see_pin: bit_is(count_io_pin_o, exp);
                default: bit_is(count_io_pin_oe, exp);
            endcase
            @(posedge clk);
        end
    endtask
    task wr(input reg [7:0] a, input reg [31:0] d);
        begin
            u_cpu.xfer(1'b1, a, d, q);
        end
    endtask
    task chk(input reg [7:0] a, input reg [31:0] e);
        begin
            u_cpu.xfer(1'b0, a, 32'h0000_0000, q);
            cmp(q, e);
        end
    endtask
    // slow edges so the pin synchroniser sees every level
    task falls(input integer n);
        begin
            repeat (n) begin
                pin_drv <= 1'b0;
                repeat (4) @(posedge clk);
                pin_drv <= 1'b1;
                repeat (4) @(posedge clk);
            end
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles > 20000) begin
            n_fail = n_fail + 1;
            finish_test;
        end
    end
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        pin_drv = 1'b1;
        int_pin = 1'b0;
        n_fail = 0;
        num_checks = 0;
        cycles = 0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        // ****************
        // reset values, unmapped place
        // ****************
        chk(`TMR_ADR_CTRL, 32'h0000_0000);
        chk(`TMR_ADR_T1_COUNT, 32'h0000_00FF);
        chk(`TMR_ADR_T3_COUNT, 32'h0000_FFFF);
        wr(8'h40, 32'hFFFF_FFFF);
        chk(8'h40, 32'h0000_0000);
        // ****************
        // timer 1 on pin falls, flag, irq, skip
        // ****************
        wr(`TMR_ADR_CTRL, 32'h0000_0100);
        wr(`TMR_ADR_T1_COUNT, 32'h0000_0001);
        wr(`TMR_ADR_T1_RELOAD, 32'h0000_0004);
        wr(`TMR_ADR_CTRL, 32'h0000_0102);
        falls(3);
        wr(`TMR_ADR_CTRL, 32'h0000_0100);
        chk(`TMR_ADR_T1_COUNT, 32'h0000_0003);
        chk(`TMR_ADR_IRQ_STAT, 32'h0000_0001);
        out_is(see_irq, 1'b0);
        wr(`TMR_ADR_IRQ_EN, 32'h0000_0001);
        repeat (2) @(posedge clk);
        out_is(see_irq, 1'b1);
        chk(`TMR_ADR_SKIP, 32'h0000_0000);
        wr(`TMR_ADR_IRQ_CLR, 32'h0000_0001);
        chk(`TMR_ADR_IRQ_STAT, 32'h0000_0000);
        out_is(see_irq, 1'b0);
        wr(`TMR_ADR_IRQ_EN, 32'h0000_0000);
        wr(`TMR_ADR_CTRL, 32'h0000_0102);
        falls(4);
        wr(`TMR_ADR_CTRL, 32'h0000_0100);
        chk(`TMR_ADR_SKIP, 32'h0000_0001);
        chk(`TMR_ADR_IRQ_STAT, 32'h0000_0000);
        // ****************
        // synchronised start waits for the interrupt pin
        // ****************
        wr(`TMR_ADR_CTRL, 32'h0000_0000);
        wr(`TMR_ADR_PRESCALE, 32'h0000_0000);
        wr(`TMR_ADR_T1_COUNT, 32'h0000_0020);
        wr(`TMR_ADR_CTRL, 32'h0000_0203);
        repeat (20) @(posedge clk);
        wr(`TMR_ADR_CTRL, 32'h0000_0000);
        chk(`TMR_ADR_T1_COUNT, 32'h0000_0020);
        wr(`TMR_ADR_CTRL, 32'h0000_0203);
        int_pin <= 1'b1;
        repeat (20) @(posedge clk);
        wr(`TMR_ADR_CTRL, 32'h0000_0000);
        u_cpu.xfer(1'b0, `TMR_ADR_T1_COUNT, 32'h0000_0000, q);
        bit_is(q[7:0] < 8'h20, 1'b1);
        // ****************
        // pwm on the pin, then latch override
        // ****************
        wr(`TMR_ADR_T2_RLD_LO, 32'h0000_0010);
        wr(`TMR_ADR_T2_RLD_HI, 32'h0000_0010);
        wr(`TMR_ADR_T2_COUNT, 32'h0000_0010);
        wr(`TMR_ADR_CTRL, 32'h0000_00E5);
        out_is(see_oe, 1'b1);
        // two clocks a source tick; reload + 1 ticks, high adds one extension tick
        while (count_io_pin_o !== 1'b1) @(negedge clk);
        width = 0;
        while (count_io_pin_o === 1'b1) begin
            width = width + 1;
            @(negedge clk);
        end
        cmp(width, 32'h0000_0024);
        width = 0;
        while (count_io_pin_o === 1'b0) begin
            width = width + 1;
            @(negedge clk);
        end
        cmp(width, 32'h0000_0022);
        wr(`TMR_ADR_CTRL, 32'h0000_00E0);
        wr(`TMR_ADR_CTRL, 32'h0000_0480);
        out_is(see_pin, 1'b1);
        chk(`TMR_ADR_IRQ_STAT, 32'h0000_0002);
        wr(`TMR_ADR_CTRL, 32'h0000_0000);
        out_is(see_oe, 1'b0);
        // ****************
        // lc timer: one underflow, then counts down from its fixed reload
        // ****************
        wr(`TMR_ADR_IRQ_CLR, 32'h0000_000F);
        wr(`TMR_ADR_LC_COUNT, 32'h0000_0001);
        wr(`TMR_ADR_CTRL, 32'h0000_0009);
        repeat (20) @(posedge clk);
        wr(`TMR_ADR_CTRL, 32'h0000_0000);
        chk(`TMR_ADR_IRQ_STAT, 32'h0000_0004);
        chk(`TMR_ADR_LC_COUNT, 32'h0000_0006);
        // ****************
        // prescaler data, timer 3 on the system clock, clock enable
        // ****************
        wr(`TMR_ADR_PRESCALE, 32'h0000_005A);
        chk(`TMR_ADR_PRESCALE, 32'h0000_005A);
        wr(`TMR_ADR_CTRL, 32'h0000_0800);
        wr(`TMR_ADR_CTRL, 32'h0000_0810);
        ce <= 1'b0;
        repeat (5) @(posedge clk);
        ce <= 1'b1;
        wr(`TMR_ADR_CTRL, 32'h0000_0800);
        // one tick before the freeze, three during the stop write
        chk(`TMR_ADR_T3_COUNT, 32'h0000_FFFB);
        // ****************
        // reset with the port c latch driving the pin high
        // ****************
        wr(`TMR_ADR_CTRL, 32'h0000_0480);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        chk(`TMR_ADR_CTRL, 32'h0000_0000);
        chk(`TMR_ADR_T3_COUNT, 32'h0000_FFFF);
        out_is(see_pin, 1'b0);
        out_is(see_oe, 1'b0);
        finish_test;
    end
endmodule // tmr_unit_bench

/* tmr_unit_properties.sv */
`timescale 1ns/100ps
`include "tmr_consts.vh"
module tmr_unit_properties (
    input wire        CLK_I,
    input wire        SRST_I,
    input wire        CE_I,
    input wire        CYC_I,
    input wire        STB_I,
    input wire        WE_I,
    input wire [7:0]  ADR_I,
    input wire [3:0]  SEL_I,
    input wire [31:0] DAT_I,
    input wire [31:0] DAT_O,
    input wire        ACK_O,
    input wire        COUNT_IO_PIN_I,
    input wire        COUNT_IO_PIN_O,
    input wire        COUNT_IO_PIN_OE_O,
    input wire        INT_PIN_I,
    input wire        IRQ_O
);
    reg  [11:0] ctrl_reg;
    reg  [3:0]  en_reg;
    wire        wr_ack = ACK_O && CE_I && WE_I;
    // ****************
    // shadows of control and enable, taken at the ack edge
    // ****************
    always @(posedge CLK_I) begin
        if (SRST_I) begin
            ctrl_reg <= 12'h000;
            en_reg   <= 4'h0;
        end else if (wr_ack && ADR_I == `TMR_ADR_CTRL) begin
            if (SEL_I[0]) ctrl_reg[7:0] <= DAT_I[7:0];
            if (SEL_I[1]) ctrl_reg[11:8] <= DAT_I[11:8];
        end else if (wr_ack && ADR_I == `TMR_ADR_IRQ_EN && SEL_I[0]) begin
            en_reg <= DAT_I[3:0];
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    sequence s_req;
        CYC_I && STB_I && CE_I && !ACK_O;
    endsequence
    sequence s_pulse;
        ACK_O ##1 !ACK_O;
    endsequence
    a_ack_after_req: assert property (s_req |=> s_pulse)
        else $error("no single ack after request");
    a_ack_has_req: assert property ($rose(ACK_O) |-> $past(CYC_I && STB_I))
        else $error("ack without request");
    a_reset_quiet: assert property ($fell(SRST_I) |-> !ACK_O && !IRQ_O && !COUNT_IO_PIN_OE_O
        && !COUNT_IO_PIN_O && DAT_O == 32'h0000_0000) else $error("outputs not quiet after reset");
    a_ctrl_readback: assert property (ACK_O && !WE_I && ADR_I == `TMR_ADR_CTRL
        |-> DAT_O == {20'h0_0000, ctrl_reg}) else $error("control read mismatch");
    a_unmapped_zero: assert property (ACK_O && !WE_I && ADR_I > 8'h33
        |-> DAT_O == 32'h0000_0000) else $error("unmapped read not zero");
    a_latch_drives_pin: assert property (
        ctrl_reg[10] && $past(ctrl_reg[10]) |-> COUNT_IO_PIN_O) else $error("latch high, pin low");
    a_pin_enable: assert property (ctrl_reg[7] == $past(ctrl_reg[7])
        |-> COUNT_IO_PIN_OE_O == ctrl_reg[7]) else $error("pin enable wrong");
    a_irq_masked: assert property (
        en_reg == 4'h0 && $past(en_reg) == 4'h0 |-> !IRQ_O) else $error("irq while masked");
endmodule // tmr_unit_properties
bind tmr_unit tmr_unit_properties u_props (.CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(CE_I),
    .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
    .DAT_O(DAT_O), .ACK_O(ACK_O), .COUNT_IO_PIN_I(COUNT_IO_PIN_I), .COUNT_IO_PIN_O(COUNT_IO_PIN_O),
    .COUNT_IO_PIN_OE_O(COUNT_IO_PIN_OE_O), .INT_PIN_I(INT_PIN_I), .IRQ_O(IRQ_O));
